// ==== common/clk_sel_pkg.sv ====
// Package with register map, field layout and types of the clock selection block.
package clk_sel_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] CLOCK_SOURCE_SELECT_ADDR = 8'hA9;
   localparam logic [7:0] HF_OSC_TRIM_ADDR         = 8'hB3;
   localparam logic [7:0] HF_OSC_CONTROL_ADDR      = 8'hB2;

   // ****************************************
   // Field layout and reset values
   // ****************************************
   localparam int         SRC_SEL_LSB      = 0;
   localparam int         TRIM_LSB         = 0;
   localparam int         HF_DIV_LSB       = 0;
   localparam int         SUSPEND_BIT      = 5;
   localparam logic [1:0] SRC_SEL_RESET    = 2'h0;
   localparam logic [1:0] HF_DIV_RESET     = 2'h3;
   localparam logic [6:0] TRIM_FACTORY_DEF = 7'h40;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      SRC_HF_OSC  = 2'h0,
      SRC_EXT_OSC = 2'h1,
      SRC_LF_OSC  = 2'h2,
      SRC_RSVD    = 2'h3
   } clk_src_t;

   typedef struct packed {
      logic       port0_match;
      logic       port1_match;
      logic       cmp0_enabled;
      logic       cmp0_out;
      logic       timer3_ovf;
   } wake_events_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

endpackage : clk_sel_pkg

// ==== hw/system_clock_select.sv ====
// System clock source selection, high-frequency divider, trim and suspend control.
`timescale 1ns/1ps

module system_clock_select #(
   parameter logic [6:0] TRIM_FACTORY = clk_sel_pkg::TRIM_FACTORY_DEF
) (
   input  wire logic                      REF_CLK,
   input  wire logic                      RSTN,
   input  wire clk_sel_pkg::sfr_req_t     SFR_REQ,
   input  wire clk_sel_pkg::wake_events_t WAKE,
   input  wire logic                      HF_TICK,
   input  wire logic                      EXT_TICK,
   input  wire logic                      LF_TICK,
   output logic [7:0]                     SFR_RDATA,
   output logic                           SFR_RVALID,
   output logic [1:0]                     SYSTEM_CLOCK_SRC,
   output logic [1:0]                     HF_DIV_SEL,
   output logic [6:0]                     HF_TRIM,
   output logic                           HF_OSC_RUN,
   output logic                           SYSTEM_CLOCK_EN
);
   import clk_sel_pkg::*;

   // ****************************************
   // Register state
   // ****************************************
   logic [1:0] src_sel_reg;
   logic [1:0] src_sel_next;
   logic [1:0] active_src_reg;
   logic [1:0] hf_div_reg;
   logic [1:0] active_div_reg;
   logic [6:0] trim_reg;
   logic       suspend_reg;
   logic       trim_loaded_reg;
   logic [2:0] div_cnt_reg;
   logic       tick_sel;
   logic       div_wrap;
   logic       wake_any;
   logic       wr_sel;
   logic       wr_ctl;
   logic       wr_trim;

   // Ratio of the HF divider as a count mask: 1, 2, 4 or 8 ticks per clock.
   function automatic logic [2:0] div_mask(input logic [1:0] code);
      case (code)
         2'h0:    div_mask = 3'h0;
         2'h1:    div_mask = 3'h1;
         2'h2:    div_mask = 3'h3;
         default: div_mask = 3'h7;
      endcase
   endfunction : div_mask

   assign wr_sel  = SFR_REQ.wr && (SFR_REQ.addr == CLOCK_SOURCE_SELECT_ADDR);
   assign wr_ctl  = SFR_REQ.wr && (SFR_REQ.addr == HF_OSC_CONTROL_ADDR);
   assign wr_trim = SFR_REQ.wr && (SFR_REQ.addr == HF_OSC_TRIM_ADDR);

   // ****************************************
   // Clock source selector
   // ****************************************
   always_comb begin
      src_sel_next = src_sel_reg;
      if (wr_sel && (SFR_REQ.wdata[SRC_SEL_LSB +: 2] != SRC_RSVD)) begin
         src_sel_next = SFR_REQ.wdata[SRC_SEL_LSB +: 2];
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         src_sel_reg <= SRC_SEL_RESET;
      end else begin
         src_sel_reg <= src_sel_next;
      end
   end

   // ****************************************
   // HF divider and suspend control
   // ****************************************
   // resets to divide by eight
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         hf_div_reg <= HF_DIV_RESET;
      end else if (wr_ctl) begin
         hf_div_reg <= SFR_REQ.wdata[HF_DIV_LSB +: 2];
      end
   end

   assign wake_any = WAKE.port0_match || WAKE.port1_match
                  || (WAKE.cmp0_enabled && !WAKE.cmp0_out) || WAKE.timer3_ovf;

   // The wake event wins over a suspend write in the same cycle.
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         suspend_reg <= 1'b0;
      end else if (suspend_reg && wake_any) begin
         suspend_reg <= 1'b0;
      end else if (wr_ctl && SFR_REQ.wdata[SUSPEND_BIT] && !wake_any) begin
         suspend_reg <= 1'b1;
      end
   end

   // ****************************************
   // Trim register
   // ****************************************
   // TRIM_FACTORY_DEF at reset, TRIM_FACTORY on the first clock after reset
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         trim_reg        <= TRIM_FACTORY_DEF;
         trim_loaded_reg <= 1'b0;
      end else begin
         trim_loaded_reg <= 1'b1;
         if (!trim_loaded_reg) begin
            trim_reg <= TRIM_FACTORY;
         end else if (wr_trim) begin
            trim_reg <= SFR_REQ.wdata[TRIM_LSB +: 7];
         end
      end
   end

   // ****************************************
   // Glitch-free switching
   // ****************************************
   always_comb begin
      case (active_src_reg)
         SRC_HF_OSC:  tick_sel = HF_TICK && !suspend_reg;
         SRC_EXT_OSC: tick_sel = EXT_TICK;
         SRC_LF_OSC:  tick_sel = LF_TICK;
         default:     tick_sel = HF_TICK;
      endcase
   end

   assign div_wrap = (active_src_reg != SRC_HF_OSC)
                  || ((div_cnt_reg & div_mask(active_div_reg)) == div_mask(active_div_reg));

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         div_cnt_reg <= 3'h0;
      end else if (tick_sel) begin
         div_cnt_reg <= div_wrap ? 3'h0 : div_cnt_reg + 3'h1;
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         active_src_reg <= SRC_SEL_RESET;
         active_div_reg <= HF_DIV_RESET;
      end else if ((tick_sel && div_wrap) || (suspend_reg && active_src_reg == SRC_HF_OSC)) begin
         active_src_reg <= src_sel_reg;
         active_div_reg <= hf_div_reg;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         SYSTEM_CLOCK_EN  <= 1'b0;
         SYSTEM_CLOCK_SRC <= SRC_SEL_RESET;
         HF_DIV_SEL <= HF_DIV_RESET;
         HF_TRIM    <= TRIM_FACTORY_DEF;
         HF_OSC_RUN <= 1'b1;
      end else begin
         SYSTEM_CLOCK_EN  <= tick_sel && div_wrap;
         SYSTEM_CLOCK_SRC <= active_src_reg;
         HF_DIV_SEL <= active_div_reg;
         HF_TRIM    <= trim_reg;
         HF_OSC_RUN <= !suspend_reg;
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         SFR_RDATA  <= 8'h00;
         SFR_RVALID <= 1'b0;
      end else begin
         SFR_RVALID <= SFR_REQ.rd;
         case (SFR_REQ.addr)
            CLOCK_SOURCE_SELECT_ADDR: SFR_RDATA <= {6'h00, src_sel_reg};
            HF_OSC_TRIM_ADDR:         SFR_RDATA <= {1'b0, trim_reg};
            HF_OSC_CONTROL_ADDR:      SFR_RDATA <= {2'h0, suspend_reg, 3'h0, hf_div_reg};
            default:                  SFR_RDATA <= 8'h00;
         endcase
      end
   end

endmodule : system_clock_select

// ==== test/system_clock_select_checker.sv ====
// Checker for the clock selection block ports.
`timescale 1ns/1ps
module system_clock_select_checker (
   input wire logic                      REF_CLK,
   input wire logic                      RSTN,
   input wire clk_sel_pkg::sfr_req_t     SFR_REQ,
   input wire clk_sel_pkg::wake_events_t WAKE,
   input wire logic                      HF_TICK,
   input wire logic [7:0]                SFR_RDATA,
   input wire logic                      SFR_RVALID,
   input wire logic [1:0]                SYSTEM_CLOCK_SRC,
   input wire logic [1:0]                HF_DIV_SEL,
   input wire logic                      HF_OSC_RUN,
   input wire logic                      SYSTEM_CLOCK_EN
);
   import clk_sel_pkg::*;
   wire logic wk = WAKE.port0_match | WAKE.port1_match | WAKE.timer3_ovf
                 | (WAKE.cmp0_enabled & ~WAKE.cmp0_out);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RSTN);
   // ****************************************
   // Properties
   // ****************************************
   AST_SEL_ZERO: assert property (
      SFR_REQ.rd && SFR_REQ.addr == CLOCK_SOURCE_SELECT_ADDR |=> SFR_RDATA[7:2] == 6'h00)
      else $error("select high bits set");
   AST_TRIM_ZERO: assert property (
      SFR_REQ.rd && SFR_REQ.addr == HF_OSC_TRIM_ADDR |=> !SFR_RDATA[7])
      else $error("trim bit 7 set");
   AST_RVALID: assert property (SFR_REQ.rd |=> SFR_RVALID)
      else $error("read not answered");
   AST_NO_RSVD: assert property (SYSTEM_CLOCK_SRC != SRC_RSVD)
      else $error("reserved source in use");
   AST_SUSP_STOP: assert property (
      !HF_OSC_RUN && !$past(HF_OSC_RUN) && SYSTEM_CLOCK_SRC == SRC_HF_OSC |-> !SYSTEM_CLOCK_EN)
      else $error("clock ran while suspended");
   AST_WAKE: assert property (!HF_OSC_RUN && wk |-> ##[1:3] HF_OSC_RUN)
      else $error("no wake");
   AST_DIV1: assert property (
      HF_TICK ##1 (HF_OSC_RUN && SYSTEM_CLOCK_SRC == SRC_HF_OSC && HF_DIV_SEL == 2'h0)
      |-> SYSTEM_CLOCK_EN)
      else $error("missing enable at divide by one");
   AST_DIV8_GAP: assert property (
      SYSTEM_CLOCK_EN ##1 (!SYSTEM_CLOCK_EN && SYSTEM_CLOCK_SRC == SRC_HF_OSC && HF_DIV_SEL == 2'h3)
      |=> !SYSTEM_CLOCK_EN [*5])
      else $error("short period at divide by eight");
   COV_LF: cover property (SYSTEM_CLOCK_SRC == SRC_LF_OSC && SYSTEM_CLOCK_EN);
   COV_WAKE: cover property (!HF_OSC_RUN ##1 HF_OSC_RUN);
   COV_DIV8: cover property (HF_DIV_SEL == 2'h3 && SYSTEM_CLOCK_EN);
endmodule : system_clock_select_checker
bind system_clock_select system_clock_select_checker system_clock_select_checker_inst (.*);

// ==== test/system_clock_select_tb.sv ====
// Self-checking bench for the clock selection block.
`timescale 1ns/1ps
module system_clock_select_tb;
   import clk_sel_pkg::*;
   logic         ref_clk = 0, rstn = 0, ext = 0, lf = 0;
   logic [3:0]   tcnt = 4'h0;
   sfr_req_t     req = '0;
   wake_events_t wake = '0;
   wake_events_t wk [5] = '{5'h10, 5'h08, 5'h04, 5'h01, 5'h06};
   logic [7:0]   rdata;
   logic [1:0]   src, div;
   logic [6:0]   trim;
   logic         rvalid, run, en;
   int           failures = 0, check_count = 0, k;
   always #2 ref_clk = ~ref_clk;
   system_clock_select system_clock_select_inst (.REF_CLK(ref_clk), .RSTN(rstn), .SFR_REQ(req),
      .WAKE(wake), .HF_TICK(1'b1), .EXT_TICK(ext), .LF_TICK(lf), .SFR_RDATA(rdata),
      .SFR_RVALID(rvalid), .SYSTEM_CLOCK_SRC(src), .HF_DIV_SEL(div), .HF_TRIM(trim),
      .HF_OSC_RUN(run), .SYSTEM_CLOCK_EN(en));
   // External source ticks every 2 cycles, low-frequency source every 4.
   always @(negedge ref_clk) begin
      tcnt <= tcnt + 4'h1;
      ext  <= tcnt[0];
      lf   <= tcnt[1:0] == 2'h0;
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge ref_clk);
      req.wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge ref_clk);
      cmp({7'h0, rvalid}, 8'h01);
      cmp(rdata, exp);
      req.rd = 1'b0;
   endtask : rd
   task automatic count_en(input int n);
      k = 0;
      repeat (n) @(negedge ref_clk) k += int'(en === 1'b1);
   endtask : count_en
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      #20000;
      failures++;
      stop_test();
   end
   initial begin
      repeat (4) @(negedge ref_clk);
      rstn = 1'b1;
      rd(CLOCK_SOURCE_SELECT_ADDR, 8'h00);
      rd(HF_OSC_CONTROL_ADDR, 8'h03);
      rd(HF_OSC_TRIM_ADDR, {1'b0, TRIM_FACTORY_DEF});
      rd(8'h00, 8'h00);
      for (int s = 0; s < 3; s++) begin
         wr(CLOCK_SOURCE_SELECT_ADDR, 8'hFC | 8'(s));
         repeat (20) @(negedge ref_clk);
         cmp({6'h0, src}, 8'(s));
         rd(CLOCK_SOURCE_SELECT_ADDR, 8'(s));
      end
      wr(CLOCK_SOURCE_SELECT_ADDR, 8'h03);
      repeat (20) @(negedge ref_clk);
      cmp({6'h0, src}, 8'h02);
      wr(CLOCK_SOURCE_SELECT_ADDR, 8'h00);
      for (int d = 0; d < 4; d++) begin
         wr(HF_OSC_CONTROL_ADDR, 8'(d));
         repeat (20) @(negedge ref_clk);
         count_en(64);
         cmp(k[7:0], 8'(64 >> d));
         cmp({6'h0, div}, 8'(d));
      end
      wr(HF_OSC_TRIM_ADDR, 8'hFF);
      rd(HF_OSC_TRIM_ADDR, 8'h7F);
      cmp({1'b0, trim}, 8'h7F);
      wr(HF_OSC_TRIM_ADDR, 8'h80);
      rd(HF_OSC_TRIM_ADDR, 8'h00);
      // The last pattern has the comparator enabled but high, so it must not wake.
      for (int w = 0; w < 5; w++) begin
         wr(HF_OSC_CONTROL_ADDR, 8'h20);
         rd(HF_OSC_CONTROL_ADDR, 8'h20);
         count_en(16);
         cmp({7'h0, run}, 8'h00);
         cmp(k[7:0], 8'h00);
         wake = wk[w];
         @(negedge ref_clk);
         wake = '0;
         repeat (4) @(negedge ref_clk);
         cmp({7'h0, run}, {7'h0, w != 4});
         count_en(16);
         cmp(k[7:0], (w != 4) ? 8'h10 : 8'h00);
      end
      rstn = 1'b0;
      repeat (2) @(negedge ref_clk);
      cmp({6'h0, div}, 8'h03);
      cmp({7'h0, run}, 8'h01);
      rstn = 1'b1;
      rd(HF_OSC_CONTROL_ADDR, 8'h03);
      rd(CLOCK_SOURCE_SELECT_ADDR, 8'h00);
      stop_test();
   end
endmodule : system_clock_select_tb
